// ---- async_serial_receiver.sv ----
`timescale 1ns/1ps
// Receive side of an asynchronous serial interface with holding buffer and status register
module async_serial_receiver (
   input  wire logic        ref_clk,        // 250 MHz master clock
   input  wire logic        sys_rst,        // Asynchronous reset, active high
   input  wire logic        rx_line,        // Serial input, synchronous to ref_clk
   input  wire logic [1:0]  frame_format,   // Frame format select
   input  wire logic        parity_odd,     // 1 = odd parity, 0 = even
   input  wire logic [11:0] presc,          // Oversampling divider, zero counts as one
   input  wire logic        reg_rd,         // Register read strobe
   input  wire logic [7:0]  reg_addr,       // Register index
   output logic      [7:0]  reg_rdata,      // Read data, registered
   output logic             line_break_irq  // One-cycle line break request
);
   // Receiver states
   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_START  = 3'b001,
      S_DATA   = 3'b010,
      S_EXTRA  = 3'b011,
      S_STOP   = 3'b100,
      S_STOP2  = 3'b101
   } rx_state_t;

   rx_state_t   state_q;        // Recovery state
   logic [11:0] div_q;          // Oversampling divider count
   logic        tick_q;         // One-cycle 16x enable
   logic [3:0]  phase_q;        // Position inside a bit, 0..15
   logic [1:0]  highs_q;        // Consecutive idle high samples
   logic [2:0]  smp_q;          // Three middle samples
   logic [3:0]  bitn_q;         // Data bits taken
   logic [8:0]  shift_q;        // Assembled character
   logic        noise_acc_q;    // Noise seen in this character
   logic        frame_acc_q;    // Frame error seen in this character
   logic        done_q;         // Character complete pulse
   logic [3:0]  low_bits_q;     // Consecutive bit periods voted low
   logic        bit_v;          // Voted bit value
   logic        bit_noisy;      // Vote disagreement
   logic        bit_end;        // Last tick of a bit period
   logic [7:0]  rx_holding_buffer_q; // Character seen by the core
   logic        ninth_rx_bit_q;      // Ninth bit of held character
   logic        rx_full_flag_q;      // Holding buffer full
   logic        overrun_flag_q;      // New character hit unread buffer
   logic        noise_error_flag_q;  // Noise on loaded character
   logic        frame_error_flag_q;  // Frame error on loaded character
   logic        data_rd;             // Core reads data register

   // Majority vote over the middle three samples
   rx_majority u_vote (
      .samples   (smp_q),
      .bit_value (bit_v),
      .noisy     (bit_noisy)
   );

   // Last tick of a bit period: the vote is complete and the state steps here
   assign bit_end = tick_q && (phase_q == rx_pkg::TICKS_LAST);
   // Only a data register read has a side effect; status reads are free
   assign data_rd = reg_rd && (reg_addr == rx_pkg::RX_DATA_ADDR);

   // 16x oversampling enable from the master clock
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q  <= 12'h000;
         tick_q <= 1'b0;
      // Zero and one both tick every cycle, so no divider value stalls the receiver
      end else if (div_q + 12'h001 >= presc) begin
         div_q  <= 12'h000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 12'h001;
         tick_q <= 1'b0;
      end
   end

   // Middle samples collected for the vote; line sampled only on ticks
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         smp_q <= 3'h0;
      end else if (tick_q) begin
         // Taken mid bit, away from the edges where a slow line is uncertain
         if (phase_q == rx_pkg::SAMPLE_A) begin
            smp_q[0] <= rx_line;
         end
         if (phase_q == rx_pkg::SAMPLE_B) begin
            smp_q[1] <= rx_line;
         end
         if (phase_q == rx_pkg::SAMPLE_C) begin
            smp_q[2] <= rx_line;
         end
      end
   end

   // Recovery state machine on the 16x enable
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q     <= S_IDLE;
         phase_q     <= 4'h0;
         highs_q     <= 2'h0;
         bitn_q      <= 4'h0;
         shift_q     <= 9'h000;
         noise_acc_q <= 1'b0;
         frame_acc_q <= 1'b0;
         done_q      <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (tick_q) begin
            phase_q <= phase_q + 4'h1;
            case (state_q)
               S_IDLE: begin
                  // Detection tick counts as phase zero of the start bit; the next tick is phase one
                  phase_q <= 4'h1;
                  // Low after three highs starts a frame; glitches alone cannot
                  if (!rx_line && highs_q == rx_pkg::IDLE_HIGHS) begin
                     state_q     <= S_START;
                     noise_acc_q <= 1'b0;
                     frame_acc_q <= 1'b0;
                     bitn_q      <= 4'h0;
                     highs_q     <= 2'h0;
                  end else if (rx_line && highs_q != rx_pkg::IDLE_HIGHS) begin
                     // Count highs up to three, then saturate
                     highs_q <= highs_q + 2'h1;
                  end else if (!rx_line) begin
                     // A low before three highs restarts the count
                     highs_q <= 2'h0;
                  end
               end
               S_START: begin
                  if (bit_end) begin
                     noise_acc_q <= bit_noisy;
                     // A start that votes high was a glitch: back to idle
                     state_q     <= bit_v ? S_IDLE : S_DATA;
                  end
               end
               S_DATA: begin
                  if (bit_end) begin
                     // LSB first: each bit enters at the top and walks down
                     shift_q     <= {1'b0, bit_v, shift_q[7:1]};
                     noise_acc_q <= noise_acc_q | bit_noisy;
                     bitn_q      <= bitn_q + 4'h1;
                     // Eighth data bit: an extra bit follows only in the parity and nine-bit formats
                     if (bitn_q == rx_pkg::DATA_BITS_8 - 4'h1) begin
                        state_q <= (frame_format == rx_pkg::FMT_8P1 || frame_format == rx_pkg::FMT_9N1)
                                   ? S_EXTRA : S_STOP;
                     end
                  end
               end
               S_EXTRA: begin
                  if (bit_end) begin
                     noise_acc_q <= noise_acc_q | bit_noisy;
                     // Parity or ninth data bit waits in the top of the shift register
                     shift_q[8]  <= bit_v;
                     // Parity bit: total ones plus odd select must be even
                     if (frame_format == rx_pkg::FMT_8P1 && ((^shift_q[7:0]) ^ bit_v ^ parity_odd)) begin
                        frame_acc_q <= 1'b1;
                     end
                     state_q <= S_STOP;
                  end
               end
               S_STOP: begin
                  if (bit_end) begin
                     // A low stop is flagged, yet the character is still delivered
                     noise_acc_q <= noise_acc_q | bit_noisy;
                     if (!bit_v) begin
                        frame_acc_q <= 1'b1;
                     end
                     if (frame_format == rx_pkg::FMT_8N2) begin
                        state_q <= S_STOP2;
                     end else begin
                        state_q <= S_IDLE;
                        done_q  <= 1'b1;
                     end
                  end
               end
               S_STOP2: begin
                  if (bit_end) begin
                     // Second stop bit of the two-stop format, checked like the first
                     noise_acc_q <= noise_acc_q | bit_noisy;
                     if (!bit_v) begin
                        frame_acc_q <= 1'b1;
                     end
                     state_q <= S_IDLE;
                     done_q  <= 1'b1;
                  end
               end
               default: begin
                  // Unused state codes fall back to idle
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Line break: count bit periods voted low, one request at the tenth
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_bits_q     <= 4'h0;
         line_break_irq <= 1'b0;
      end else begin
         line_break_irq <= 1'b0;
         if (bit_end && state_q != S_IDLE) begin
            if (bit_v) begin
               // Any high bit breaks the run
               low_bits_q <= 4'h0;
            end else if (low_bits_q != rx_pkg::BREAK_BITS) begin
               // Held at ten, so a long break raises one request only
               low_bits_q <= low_bits_q + 4'h1;
               if (low_bits_q == rx_pkg::BREAK_BITS - 4'h1) begin
                  line_break_irq <= 1'b1;
               end
            end
         end else if (state_q == S_IDLE && tick_q && rx_line) begin
            // A stalled low line in idle keeps the count; a high clears it
            low_bits_q <= 4'h0;
         end
      end
   end

   // Holding buffer load; an overrun keeps the unread character
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_holding_buffer_q <= rx_pkg::DATA_RESET;
         ninth_rx_bit_q      <= 1'b0;
         noise_error_flag_q  <= 1'b0;
         frame_error_flag_q  <= 1'b0;
      end else if (done_q && (!rx_full_flag_q || data_rd)) begin
         // A read in the same cycle frees the buffer for the new character
         rx_holding_buffer_q <= shift_q[7:0];
         ninth_rx_bit_q      <= (frame_format == rx_pkg::FMT_9N1) ? shift_q[8] : 1'b0;
         // Error flags follow each loaded character; they are not sticky
         noise_error_flag_q  <= noise_acc_q;
         frame_error_flag_q  <= frame_acc_q;
      end
   end

   // Full flag: set on load wins over the clearing read
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_full_flag_q <= 1'b0;
      end else if (done_q) begin
         // A load in the clearing cycle leaves the buffer full
         rx_full_flag_q <= 1'b1;
      end else if (data_rd) begin
         rx_full_flag_q <= 1'b0;
      end
   end

   // Overrun: sticky until the data register is read; a read in the completing cycle prevents one
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         overrun_flag_q <= 1'b0;
      end else if (done_q && rx_full_flag_q && !data_rd) begin
         // Buffer still unread when a new character completes
         overrun_flag_q <= 1'b1;
      end else if (data_rd) begin
         overrun_flag_q <= 1'b0;
      end
   end

   // Registered read port; unmapped indices read zero
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= rx_pkg::STATUS_RESET;
      end else if (reg_rd) begin
         case (reg_addr)
            rx_pkg::RX_DATA_ADDR: begin
               reg_rdata <= rx_holding_buffer_q;
            end
            rx_pkg::RX_STATUS_ADDR: begin
               // Bits 3, 1 and 0 are unused and read zero
               reg_rdata <= 8'h00;
               reg_rdata[rx_pkg::ST_NOISE]   <= noise_error_flag_q;
               reg_rdata[rx_pkg::ST_FRAME]   <= frame_error_flag_q;
               reg_rdata[rx_pkg::ST_FULL]    <= rx_full_flag_q;
               reg_rdata[rx_pkg::ST_OVERRUN] <= overrun_flag_q;
               reg_rdata[rx_pkg::ST_NINTH]   <= ninth_rx_bit_q;
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end
   end
endmodule : async_serial_receiver

// ---- rx_pkg.sv ----
// Package for the asynchronous serial receiver: offsets, field positions, timing
package rx_pkg;
   // Register indices, as printed
   localparam logic [7:0] RX_DATA_ADDR   = 8'h24;
   localparam logic [7:0] RX_STATUS_ADDR = 8'h35;
   // Status register bit positions
   localparam int ST_NOISE   = 7;
   localparam int ST_FRAME   = 6;
   localparam int ST_FULL    = 5;
   localparam int ST_OVERRUN = 4;
   localparam int ST_NINTH   = 2;
   // Reset values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET   = 8'h00;
   // Oversampling: last tick of a bit, majority sample points, idle highs before start, break and data bit counts
   localparam logic [3:0] TICKS_LAST   = 4'hF;
   localparam logic [3:0] SAMPLE_A     = 4'h7;
   localparam logic [3:0] SAMPLE_B     = 4'h8;
   localparam logic [3:0] SAMPLE_C     = 4'h9;
   localparam logic [1:0] IDLE_HIGHS   = 2'h3;
   localparam logic [3:0] BREAK_BITS   = 4'hA;
   localparam logic [3:0] DATA_BITS_8  = 4'h8;
   // Default oversampling divider: 250 MHz / (16 * 115200) rounded
   localparam logic [11:0] PRESC_DEFAULT = 12'h088;
   // Frame formats
   typedef enum logic [1:0] {
      FMT_8N1 = 2'b00,
      FMT_8N2 = 2'b01,
      FMT_8P1 = 2'b10,
      FMT_9N1 = 2'b11
   } frame_fmt_t;
endpackage : rx_pkg

// ---- rx_majority.sv ----
`timescale 1ns/1ps
// Three-sample majority vote with disagreement flag
module rx_majority (
   input  wire logic [2:0] samples,   // Three samples of one bit
   output logic            bit_value, // Majority value
   output logic            noisy      // Samples disagree
);
   // Majority and disagreement, purely combinational
   always_comb begin
      bit_value = (samples[0] & samples[1]) | (samples[1] & samples[2]) | (samples[0] & samples[2]);
      noisy     = ~((&samples) | ~(|samples));
   end
endmodule : rx_majority

// ---- async_serial_receiver_checker.sv ----
// Port assertions for the serial receiver
`timescale 1ns/1ps
module async_serial_receiver_checker (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        rx_line,
   input wire logic [1:0]  frame_format,
   input wire logic        parity_odd,
   input wire logic [11:0] presc,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_rdata,
   input wire logic        line_break_irq
);
   localparam int BREAK_MIN = 128; // Ten bit periods less phase slack
   logic [15:0]   low_cnt_q;       // Cycles of unbroken low line
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Low run length; saturates so a long break cannot wrap it
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) low_cnt_q <= 16'h0000;
      else if (rx_line) low_cnt_q <= 16'h0000;
      else if (low_cnt_q != 16'hFFFF) low_cnt_q <= low_cnt_q + 16'h0001;
   end
   reset_idle_a: assert property ($fell(sys_rst) |-> reg_rdata == rx_pkg::DATA_RESET && !line_break_irq)
      else $error("outputs not idle after reset");
   unmapped_read_a: assert property (reg_rd && reg_addr != rx_pkg::RX_DATA_ADDR
      && reg_addr != rx_pkg::RX_STATUS_ADDR |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   status_pad_a: assert property (reg_rd && reg_addr == rx_pkg::RX_STATUS_ADDR |=> (reg_rdata & 8'h0B) == 8'h00)
      else $error("unused status bits set");
   ninth_zero_a: assert property (reg_rd && reg_addr == rx_pkg::RX_STATUS_ADDR
      && frame_format != 2'b11 |=> !reg_rdata[rx_pkg::ST_NINTH]) else $error("ninth bit outside nine-bit format");
   full_clear_a: assert property (reg_rd && reg_addr == rx_pkg::RX_DATA_ADDR ##2 reg_rd
      && reg_addr == rx_pkg::RX_STATUS_ADDR |=> reg_rdata[5:4] == 2'b00) else $error("flags left after data read");
   irq_pulse_a: assert property (line_break_irq |=> !line_break_irq)
      else $error("break request longer than one cycle");
   irq_low_a: assert property (line_break_irq |-> low_cnt_q >= BREAK_MIN)
      else $error("break request without ten low bits");
endmodule : async_serial_receiver_checker

// ---- serial_line_tx.sv ----
// Remote transmitter model driving the receive line
`timescale 1ns/1ps
module serial_line_tx (
   input  wire logic ref_clk, // Bench clock
   output logic      rx_line  // Line, idle high
);
   initial rx_line = 1'b1;    // Mark level while idle
   // One frame LSB first; bad flips parity in format 10, else lowers the stop
   task automatic send(input logic [8:0] v, input logic [1:0] fmt, input logic odd,
                       input int bl, input int nz, input logic bad);
      logic [11:0] b;
      int          n;
      b = {3'b111, v[7:0], 1'b0}; // Start, eight data, stop level above
      n = 9;
      if (fmt[1]) begin // Parity or ninth bit
         b[n] = fmt[0] ? v[8] : ^v[7:0] ^ odd ^ bad;
         n++;
      end
      b[n] = (fmt == 2'b10) | !bad;
      n = n + ((fmt == 2'b01) ? 2 : 1); // Second stop
      for (int i = 0; i < n; i++) begin
         // Glitch only mid bit, so the vote still wins
         for (int c = 0; c < bl; c++) begin
            @(posedge ref_clk) rx_line <= (i == nz && c == 8) ? !b[i] : b[i];
         end
      end
      @(posedge ref_clk) rx_line <= 1'b1;
   endtask : send
   // Steady low for a break
   task automatic hold_low(input int cyc);
      repeat (cyc) @(posedge ref_clk) rx_line <= 1'b0;
      @(posedge ref_clk) rx_line <= 1'b1;
   endtask : hold_low
endmodule : serial_line_tx

// ---- async_serial_receiver_tb.sv ----
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module async_serial_receiver_tb;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        rx_line;
   logic [1:0]  frame_format = 2'b00;
   logic        parity_odd = 1'b0;
   logic [11:0] presc = 12'h001;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_rdata;
   logic        line_break_irq;
   logic [7:0]  d;                 // Last read value
   int          failures = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          irq_seen = 0;
   int          seed;
   int          m_data = 0, m_full = 0, m_ovr = 0; // Reference holding buffer
   int          m_noise = 0, m_frame = 0, m_ninth = 0;
   initial forever #2 ref_clk = ~ref_clk;
   serial_line_tx tx (.ref_clk(ref_clk), .rx_line(rx_line));
   async_serial_receiver dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx_line(rx_line),
      .frame_format(frame_format), .parity_odd(parity_odd), .presc(presc), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_rdata(reg_rdata), .line_break_irq(line_break_irq));
   // Break pulses and hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (line_break_irq === 1'b1) irq_seen++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One read; data lands on the taking edge and is sampled at the next negedge
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk) reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk) reg_rd <= 1'b0;
      @(negedge ref_clk) d = reg_rdata;
   endtask : rd
   function automatic logic [7:0] stat();
      logic [7:0] s;
      s = 8'h00;
      s[rx_pkg::ST_NOISE] = m_noise[0];
      s[rx_pkg::ST_FRAME] = m_frame[0];
      s[rx_pkg::ST_FULL] = m_full[0];
      s[rx_pkg::ST_OVERRUN] = m_ovr[0];
      s[rx_pkg::ST_NINTH] = m_ninth[0];
      return s;
   endfunction : stat
   // Model: a full buffer keeps its contents and flags overrun
   task automatic load(input logic [8:0] v, input logic [1:0] fmt, input int nz, input logic bad);
      if (m_full != 0) m_ovr = 1;
      else begin
         m_data = v[7:0];
         m_full = 1;
         m_noise = (nz >= 0);
         m_frame = bad;
         m_ninth = (fmt == 2'b11) && v[8];
      end
   endtask : load
   task automatic frame(input logic [8:0] v, input logic [1:0] fmt, input logic odd, input int nz, input logic bad);
      @(posedge ref_clk) frame_format <= fmt;
      parity_odd <= odd;
      @(posedge ref_clk);
      tx.send(v, fmt, odd, 16 * int'(presc), nz, bad);
      repeat (8) @(posedge ref_clk);
      load(v, fmt, nz, bad);
   endtask : frame
   task automatic verify(input string name);
      rd(rx_pkg::RX_STATUS_ADDR);
      chk("status", stat(), d);
      rd(rx_pkg::RX_DATA_ADDR);
      chk("data", 8'(m_data), d);
      m_full = 0;
      m_ovr = 0;
      rd(rx_pkg::RX_STATUS_ADDR);
      chk("status after read", stat(), d);
      $display("test %s done", name);
   endtask : verify
   initial begin
      seed = $urandom(32'hDDAF);
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      verify("reset");
      rd(8'h30);
      chk("unmapped", 8'h00, d);
      // Eight-bit formats with both parity senses
      for (int f = 0; f < 3; f++) begin
         for (int p = 0; p < 2; p++) begin
            frame(9'($urandom), 2'(f), p[0], -1, 1'b0);
            verify("format");
         end
      end
      frame(9'($urandom), 2'b10, 1'b1, -1, 1'b1);
      verify("parity error");
      frame(9'($urandom), 2'b00, 1'b0, -1, 1'b1);
      verify("stop error");
      frame(9'($urandom), 2'b00, 1'b0, 3, 1'b0);
      verify("noise");
      frame(9'($urandom), 2'b00, 1'b0, -1, 1'b0);
      frame(9'($urandom), 2'b01, 1'b0, -1, 1'b0);
      verify("overrun");
      @(posedge ref_clk) presc <= 12'h002;
      frame(9'($urandom), 2'b00, 1'b0, -1, 1'b0);
      verify("slow rate");
      @(posedge ref_clk) presc <= 12'h001;
      irq_seen = 0;
      tx.hold_low(12 * 16);
      repeat (16) @(posedge ref_clk);
      load(9'h000, 2'b00, -1, 1'b1);
      chk("break pulses", 8'h01, 8'(irq_seen));
      verify("break");
      // Reset in mid-run while the buffer holds a flagged character
      frame(9'($urandom), 2'b00, 1'b0, 3, 1'b1);
      @(posedge ref_clk) sys_rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      m_data = 0;
      m_full = 0;
      m_ovr = 0;
      m_noise = 0;
      m_frame = 0;
      m_ninth = 0;
      verify("mid reset");
      for (int p = 0; p < 2; p++) begin
         frame({p[0], 8'($urandom)}, 2'b11, 1'b0, -1, 1'b0);
         verify("ninth bit");
      end
      conclude();
   end
endmodule : async_serial_receiver_tb
bind async_serial_receiver async_serial_receiver_checker chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .rx_line(rx_line), .frame_format(frame_format), .parity_odd(parity_odd), .presc(presc),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .line_break_irq(line_break_irq));
